// ===== src/tpio_top.sv
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`default_nettype none
module tpio_top
	import tpio_pkg::*;
#(
	parameter int unsigned CW = TPIO_CW
)(
	// Bus
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Timer side
	input  wire logic [TPIO_NCH-1:0] run,
	input  wire logic [CW-1:0]       count [TPIO_NCH],
	input  wire logic                ch1_count_step,
	input  wire logic [15:0]         pin_in,
	output logic [15:0]              pin_out,
	output logic [15:0]              pin_oe_n,
	output logic [15:0]              events
);
	// --------------------------------------------------------------
	// Slot map: 16 slots = A,B,C,D per channel 0,3,4, channels 1,2 have A,B
	// --------------------------------------------------------------
	localparam int unsigned NS = 16;
	// Slot order: ch0 A B C D, ch1 A B, ch2 A B, ch3 A B C D, ch4 A B C D
	localparam logic [2:0] SLOT_CH [NS] = '{3'h0,3'h0,3'h0,3'h0,3'h1,3'h1,3'h2,3'h2,
		3'h3,3'h3,3'h3,3'h3,3'h4,3'h4,3'h4,3'h4};
	localparam logic [1:0] SLOT_KIND [NS] = '{2'h0,2'h1,2'h2,2'h3,2'h0,2'h1,2'h0,2'h1,
		2'h0,2'h1,2'h2,2'h3,2'h0,2'h1,2'h2,2'h3};
	// Register index (0..7) of the control register holding the slot
	localparam logic [2:0] SLOT_REG [NS] = '{3'h0,3'h0,3'h1,3'h1,3'h2,3'h2,3'h3,3'h3,
		3'h4,3'h4,3'h5,3'h5,3'h6,3'h6,3'h7,3'h7};

	typedef struct packed {
		logic [7:0][7:0]        ctl;
		logic [7:0]             ctl_wr;
		logic [TPIO_MODE_W-1:0] mode;
		logic                   ap_valid;
		logic                   ap_write;
		logic [11:0]            ap_addr;
		logic [31:0]            rdata;
		logic [15:0]            pins;
		logic [15:0]            evts;
	} tpio_state_t;

	tpio_state_t s_r, s_nxt;
	logic [NS-1:0]    slot_pin, slot_evt;
	logic [CW-1:0]    slot_gr [NS];

	// --------------------------------------------------------------
	// Channel slots
	// --------------------------------------------------------------
	generate
		for (genvar i = 0; i < NS; i++)
		begin : g_slot
			logic [3:0] fld;
			logic       dis, xs;
			// Buffer mode bits: a at 2k, b at 2k+1 for channels 0,3,4 (k=0,1,2)
			localparam int unsigned MK = (SLOT_CH[i] == 3'h0) ? 0 :
				(SLOT_CH[i] == 3'h3) ? 2 : 4;
			assign fld = SLOT_KIND[i][0] ? s_r.ctl[SLOT_REG[i]][7:4]
				: s_r.ctl[SLOT_REG[i]][3:0];
			assign dis = (SLOT_KIND[i] == 2'h2) ? s_r.mode[MK] :
				(SLOT_KIND[i] == 2'h3) ? s_r.mode[MK+1] : 1'b0;
			if (i == 4)
				assign xs = slot_evt[0];
			else if (i == 5)
				assign xs = slot_evt[2];
			else
				assign xs = ch1_count_step;
			tpio_chan #(
				.CW       (CW),
				.HAS_XC   (SLOT_CH[i] == 3'h1),
				.BIT2_IGN (SLOT_CH[i] >= 3'h2)
			) u_ch (
				.hclk        (hclk),
				.hresetn     (hresetn),
				.field       (fld),
				.field_wr    (s_r.ctl_wr[SLOT_REG[i]]),
				.disable_evt (dis),
				.run         (run[SLOT_CH[i]]),
				.count       (count[SLOT_CH[i]]),
				.pin_in      (pin_in[i]),
				.xsrc_evt    (xs),
				.pin_out     (slot_pin[i]),
				.gen_reg     (slot_gr[i]),
				.event_p     (slot_evt[i]),
				.gen_wr      (1'b0),
				.gen_wdata   ('0)
			);
		end
	endgenerate

	// --------------------------------------------------------------
	// Bus slave: zero wait states, OKAY always
	// --------------------------------------------------------------
	logic [2:0] widx;
	always_comb
	begin
		s_nxt        = s_r;
		s_nxt.ctl_wr = '0;
		s_nxt.pins   = slot_pin;
		s_nxt.evts   = slot_evt;
		widx         = s_r.ap_addr[4:2];
		if (s_r.ap_valid && s_r.ap_write)
		begin
			if (s_r.ap_addr < TPIO_OFF_MODE)
			begin
				s_nxt.ctl[widx]    = hwdata[7:0];
				s_nxt.ctl_wr[widx] = 1'b1;
			end
			else if (s_r.ap_addr == TPIO_OFF_MODE)
				s_nxt.mode = hwdata[TPIO_MODE_W-1:0];
		end
		s_nxt.ap_valid = hsel && hready && htrans == TPIO_HTRANS_NS;
		s_nxt.ap_write = hwrite;
		s_nxt.ap_addr  = haddr;
		s_nxt.rdata    = '0;
		if (s_nxt.ap_valid && !hwrite)
		begin
			if (haddr < TPIO_OFF_MODE)
				s_nxt.rdata = {24'h0, s_nxt.ctl[haddr[4:2]]};
			else if (haddr == TPIO_OFF_MODE)
				s_nxt.rdata = {26'h0, s_nxt.mode};
			else if (haddr == TPIO_OFF_PINS)
				s_nxt.rdata = {16'h0, slot_pin};
			else if (haddr == TPIO_OFF_EVT)
				s_nxt.rdata = {16'h0, slot_evt};
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// Pin enable: output when slot is in compare mode
	logic [15:0] oe_n_r;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			oe_n_r <= '0;
		else
			for (int i = 0; i < NS; i++)
				oe_n_r[i] <= SLOT_KIND[i][0] ? s_r.ctl[SLOT_REG[i]][7]
					: s_r.ctl[SLOT_REG[i]][3];
	end

	assign hrdata    = s_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign pin_out   = s_r.pins;
	assign pin_oe_n  = oe_n_r;
	assign events    = s_r.evts;

	AST_RST_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> pin_out == '0)
		else $error("pins not low after reset");
	AST_BUF_C: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.mode[0] |=> ##1 !events[2])
		else $error("buffered C register produced event");
	AST_XC: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.ctl[2][3:2] == 2'h3 && run[1] && slot_evt[0] && $stable(s_r.ctl[2])
		|=> slot_gr[4] == $past(count[1]))
		else $error("channel 1 A did not capture on channel 0 A event");
	AST_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
		s_r.ap_valid && s_r.ap_write && s_r.ap_addr == TPIO_OFF_CTL0H
		|=> s_r.ctl[0] == $past(hwdata[7:0]))
		else $error("control register write lost");
	AST_NOWAIT: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && !hresp)
		else $error("slave stalled or errored");
	COV_WR: cover property (@(posedge hclk) s_r.ctl_wr[0]);
	COV_EVT: cover property (@(posedge hclk) events[0]);
	COV_PIN: cover property (@(posedge hclk) $rose(pin_out[0]));
endmodule
`default_nettype wire

// ===== src/tpio_pkg.sv
`default_nettype none
package tpio_pkg;
	localparam int unsigned TPIO_CW         = 16;
	localparam int unsigned TPIO_NCH        = 5;
	// Register byte offsets
	localparam logic [11:0] TPIO_OFF_CTL0H  = 12'h000;
	localparam logic [11:0] TPIO_OFF_CTL0L  = 12'h004;
	localparam logic [11:0] TPIO_OFF_CTL1   = 12'h008;
	localparam logic [11:0] TPIO_OFF_CTL2   = 12'h00c;
	localparam logic [11:0] TPIO_OFF_CTL3H  = 12'h010;
	localparam logic [11:0] TPIO_OFF_CTL3L  = 12'h014;
	localparam logic [11:0] TPIO_OFF_CTL4H  = 12'h018;
	localparam logic [11:0] TPIO_OFF_CTL4L  = 12'h01c;
	localparam logic [11:0] TPIO_OFF_MODE   = 12'h020;
	localparam logic [11:0] TPIO_OFF_PINS   = 12'h024;
	localparam logic [11:0] TPIO_OFF_EVT    = 12'h028;
	// Field layout inside an 8-bit control register
	localparam int unsigned TPIO_FLD_HI_LSB = 4;
	localparam int unsigned TPIO_FLD_W      = 4;
	localparam int unsigned TPIO_BIT_CAP    = 3;
	localparam int unsigned TPIO_BIT_ALT    = 2;
	localparam int unsigned TPIO_BIT_BOTH   = 1;
	// Mode register bits: buffer mode a/b per channel 0,3,4
	localparam int unsigned TPIO_MODE_W     = 6;
	localparam logic [1:0]  TPIO_ACT_KEEP   = 2'h0;
	localparam logic [1:0]  TPIO_ACT_LOW    = 2'h1;
	localparam logic [1:0]  TPIO_ACT_HIGH   = 2'h2;
	localparam logic [1:0]  TPIO_ACT_TOG    = 2'h3;
	localparam logic [1:0]  TPIO_HTRANS_NS  = 2'h2;
	localparam logic [2:0]  TPIO_HSIZE_WORD = 3'h2;
	typedef enum logic [1:0] {TPIO_SRC_PIN, TPIO_SRC_CLK, TPIO_SRC_XC} tpio_src_t;
	// Decoded view of one 4-bit field
	typedef struct packed {
		logic       capture;
		logic       init_lvl;
		logic [1:0] action;
		logic       set_init;
		tpio_src_t  src;
	} tpio_dec_t;
endpackage
`default_nettype wire

// ===== src/tpio_chan.sv
`default_nettype none
module tpio_chan
	import tpio_pkg::*;
#(
	parameter int unsigned CW     = TPIO_CW,
	parameter bit          HAS_XC = 1'b0,
	parameter bit          BIT2_IGN = 1'b0
)(
	// Clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// Control
	input  wire logic [3:0]    field,
	input  wire logic          field_wr,
	input  wire logic          disable_evt,
	input  wire logic          run,
	input  wire logic [CW-1:0] count,
	// Capture sources
	input  wire logic          pin_in,
	input  wire logic          xsrc_evt,
	// Results, and the general register write port
	output logic               pin_out,
	output logic [CW-1:0]      gen_reg,
	output logic               event_p,
	input  wire logic          gen_wr,
	input  wire logic [CW-1:0] gen_wdata
);
	typedef struct packed {
		logic          pin;
		logic          pin_d;
		logic [CW-1:0] gr;
		logic          evt;
	} tpio_ch_state_t;

	tpio_ch_state_t s_r, s_nxt;
	tpio_dec_t      d;

	always_comb
	begin
		d.capture  = field[TPIO_BIT_CAP];
		d.init_lvl = field[TPIO_BIT_ALT];
		d.action   = field[1:0];
		d.set_init = field[1:0] != TPIO_ACT_KEEP;
		if (field[TPIO_BIT_CAP] && field[TPIO_BIT_ALT] && !BIT2_IGN)
			d.src = HAS_XC ? TPIO_SRC_XC : TPIO_SRC_CLK;
		else
			d.src = TPIO_SRC_PIN;
	end

	logic match, rise, fall, cap;
	always_comb
	begin
		match = run && !d.capture && !disable_evt && (count == s_r.gr);
		rise  = pin_in && !s_r.pin_d;
		fall  = !pin_in && s_r.pin_d;
		cap   = 1'b0;
		if (d.capture && !disable_evt && run)
		begin
			if (d.src != TPIO_SRC_PIN)
				cap = xsrc_evt;
			else if (field[TPIO_BIT_BOTH])
				cap = rise || fall;
			else if (field[0])
				cap = fall;
			else
				cap = rise;
		end
	end

	always_comb
	begin
		s_nxt       = s_r;
		s_nxt.pin_d = pin_in;
		s_nxt.evt   = match || cap;
		if (gen_wr)
			s_nxt.gr = gen_wdata;
		if (cap)
			s_nxt.gr = count;
		if (!d.capture)
		begin
			if (field_wr && !run && d.set_init)
				s_nxt.pin = d.init_lvl;
			else if (match)
			begin
				case (d.action)
					TPIO_ACT_LOW:  s_nxt.pin = 1'b0;
					TPIO_ACT_HIGH: s_nxt.pin = 1'b1;
					TPIO_ACT_TOG:  s_nxt.pin = !s_r.pin;
					default:       s_nxt.pin = s_r.pin;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign pin_out = s_r.pin;
	assign gen_reg = s_r.gr;
	assign event_p = s_r.evt;

	AST_TOGGLE: assert property (@(posedge hclk) disable iff (!hresetn)
		match && !d.capture && d.action == TPIO_ACT_TOG && !(field_wr && !run)
		|=> pin_out != $past(pin_out))
		else $error("toggle on match did not invert pin");
	AST_CAPVAL: assert property (@(posedge hclk) disable iff (!hresetn)
		cap |=> gen_reg == $past(count))
		else $error("capture did not load counter");
	AST_NOEVT_DIS: assert property (@(posedge hclk) disable iff (!hresetn)
		disable_evt |=> !event_p)
		else $error("event while register used as buffer");
endmodule
`default_nettype wire

// ===== sim/tpio_far.sv
`default_nettype none
module tpio_far
	import tpio_pkg::*;
#(
	parameter int unsigned CW = 4
)(
	// Clock
	input  wire logic                hclk,
	// From bench and design
	input  wire logic [TPIO_NCH-1:0] run,
	input  wire logic [15:0]         ext_lvl,
	input  wire logic [15:0]         pin_out,
	input  wire logic [15:0]         pin_oe_n,
	// Back to design
	output logic [CW-1:0]            count [TPIO_NCH],
	output logic                     ch1_count_step,
	output logic [15:0]              pin_in
);
	// A stopped counter parks at 1, so a restart reaches zero after 2**CW - 1 cycles
	always_ff @(posedge hclk)
	begin
		for (int i = 0; i < TPIO_NCH; i++)
			count[i] <= run[i] ? count[i] + 1'b1 : CW'(1);
	end
	assign ch1_count_step = run[1];
	// Driven pins read back their own level; released pins follow the outside
	assign pin_in = (pin_oe_n & ext_lvl) | (~pin_oe_n & pin_out);
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_top
	import tpio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned CW = 4;
	// ----------------------------------------
	// Signals and tables
	// ----------------------------------------
	logic                hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, step, ev_clr;
	logic [11:0]         haddr;
	logic [1:0]          htrans;
	logic [2:0]          hsize;
	logic [31:0]         hwdata, hrdata, q;
	logic [TPIO_NCH-1:0] run;
	logic [CW-1:0]       count [TPIO_NCH];
	logic [15:0]         pin_in, pin_out, pin_oe_n, events, ext;
	int                  ev [16];
	int                  n_fail = 0;
	int                  n_checks = 0;
	int                  cyc = 0;
	localparam logic [3:0]  CF [7] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h6, 4'h4};
	localparam bit          CI [7] = '{0, 0, 0, 1, 1, 1, 1};
	localparam bit          CA [7] = '{0, 1, 1, 0, 0, 1, 1};
	localparam logic [11:0] KA [7] = '{12'h000, 12'h000, 12'h000, 12'h000, 12'h000,
		TPIO_OFF_CTL3H, TPIO_OFF_CTL3H};
	localparam logic [7:0]  KD [7] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h80, 8'h0c, 8'h0d};
	localparam int          KS [7] = '{0, 0, 0, 0, 1, 8, 8};
	localparam int          KR [7] = '{1, 0, 1, 1, 1, 1, 0};
	localparam int          KF [7] = '{0, 1, 1, 1, 0, 0, 1};
	assign hready = hreadyout;
	tpio_top #(.CW(CW)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .run(run), .count(count),
		.ch1_count_step(step), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.events(events));
	tpio_far #(.CW(CW)) far (.hclk(hclk), .run(run), .ext_lvl(ext), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .count(count), .ch1_count_step(step), .pin_in(pin_in));
	initial
	begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	always @(posedge hclk)
	begin
		for (int i = 0; i < 16; i++)
			ev[i] <= ev_clr ? 0 : ev[i] + int'(events[i]);
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			n_fail++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= TPIO_HTRANS_NS;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic clr();
		ev_clr <= 1'b1;
		tick(1);
		ev_clr <= 1'b0;
	endtask
	task automatic run_ch(input int c, input int n);
		run[c] <= 1'b1;
		tick(n);
		run[c] <= 1'b0;
	endtask
	task automatic wrap_up();
		if (n_fail == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 12'h000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = TPIO_HSIZE_WORD;
		hwdata = 32'h0;
		run = '0;
		ext = 16'h0;
		ev_clr = 1'b0;
		tick(10);
		hresetn <= 1'b1;
		tick(1);
		`CHK("pins after reset", 16'h0, pin_out)
		wr(TPIO_OFF_CTL0H, 32'hffff_ff5a);
		bus(1'b0, TPIO_OFF_CTL0H, 32'h0);
		`CHK("ctl0h", 32'h5a, q)
		bus(1'b0, 12'h100, 32'h0);
		`CHK("unmapped", 32'h0, q)
		for (int i = 0; i < 7; i++)
		begin
			wr(TPIO_OFF_CTL0H, {28'h0, CF[i]});
			tick(3);
			`CHK("pin0 init", CI[i], pin_out[0])
			`CHK("pin0 oe_n", 1'b0, pin_oe_n[0])
			clr();
			run_ch(0, 16);
			tick(5);
			`CHK("pin0 match", CA[i], pin_out[0])
			`CHK("ev0 match", 1, ev[0])
		end
		wr(TPIO_OFF_CTL0H, 32'h3);
		clr();
		run_ch(0, 32);
		tick(5);
		`CHK("pin0 toggle twice", 1'b0, pin_out[0])
		`CHK("ev0 toggle twice", 2, ev[0])
		run[0] <= 1'b1;
		wr(TPIO_OFF_CTL0H, 32'h5);
		tick(3);
		`CHK("pin0 init while running", 1'b0, pin_out[0])
		// Capture only happens on a running counter: keep channels 0 and 3 going
		run <= 5'h09;
		for (int i = 0; i < 7; i++)
		begin
			wr(KA[i], {24'h0, KD[i]});
			tick(4);
			clr();
			ext[KS[i]] <= 1'b1;
			tick(6);
			`CHK("ev rise", KR[i], ev[KS[i]])
			clr();
			ext[KS[i]] <= 1'b0;
			tick(6);
			`CHK("ev fall", KF[i], ev[KS[i]])
		end
		run <= '0;
		wr(TPIO_OFF_CTL0H, 32'h3);
		wr(TPIO_OFF_CTL0L, 32'h33);
		wr(TPIO_OFF_CTL1, 32'hcc);
		run[1] <= 1'b1;
		for (int m = 0; m < 2; m++)
		begin
			wr(TPIO_OFF_MODE, m ? 32'h3 : 32'h0);
			clr();
			run_ch(0, 16);
			tick(5);
			`CHK("ev ch0 c", m ? 0 : 1, ev[2])
			`CHK("ev ch0 d", m ? 0 : 1, ev[3])
			`CHK("ev ch1 a", 1, ev[4])
			`CHK("ev ch1 b", m ? 0 : 1, ev[5])
		end
		run[1] <= 1'b0;
		bus(1'b0, TPIO_OFF_MODE, 32'h0);
		`CHK("mode readback", 32'h3, q)
		`CHK("hresp okay", 1'b0, hresp)
		wr(TPIO_OFF_CTL0H, 32'hc);
		tick(4);
		clr();
		run[0] <= 1'b1;
		run_ch(1, 3);
		run[0] <= 1'b0;
		tick(5);
		`CHK("ev0 from ch1 steps", 3, ev[0])
		`CHK("ch4 pins untouched", 4'h0, pin_out[15:12])
		wrap_up();
	end
endmodule
`default_nettype wire
